// ---- pioc_top.v ----
// parallel I/O controller with avalon-mm register slave
// Contract
// - output enable/disable writes set direction bits; output status reads them back.
// - programmed direction applies only while the controller owns the pin.
// - controller output drives data latch; set/clear writes change it; readable.
// - controller-owned non-output pin is left undriven.
// - peripheral-owned pin takes output value and enable from the peripheral.
// - pin level status reads the actual level of every pin.
// - per-pin glitch filter with enable, disable and status; works for any owner.
// - irq enable/disable writes of ones set/clear mask bits; mask readable.
// - any pin level change sets its irq status bit, whatever owner or direction (the code ignores changes in the 4 cycles after reset).
// - interrupt output high while any status bit is set and unmasked.
// - reading irq status clears the whole register (the code clears only the bits the read returned).
// - all registers are 32 bits, one bit position per line.
// - unimplemented bits ignore writes and read zero.
// - open-drain mode drives only low and releases otherwise.
// - open-drain enable/disable/status per pin, for either owner.
// - lines 0 to 29 implemented with one peripheral each; 30, 31 absent.
// - controller-owned line feeds peripheral input default; 1 on bit 26 else 0.
// - after reset every line is controller-owned and an input.
// - owner select enable/disable writes and owner status register.
// - default level presented to peripheral input while controller owns line.
`timescale 1ns/1ps
`default_nettype none
`include "pioc_map.vh"

module pioc_top #(
    parameter NUM_LINES = 30
) (
    input wire i_core_clk,
    input wire i_reset,
    input wire [7:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    output reg [31:0] o_avs_readdata,
    output reg o_avs_waitrequest,
    input wire [NUM_LINES-1:0] i_pin,
    output reg [NUM_LINES-1:0] o_pin,
    output reg [NUM_LINES-1:0] o_pin_oe,
    input wire [NUM_LINES-1:0] i_periph_out,
    input wire [NUM_LINES-1:0] i_periph_oe,
    output reg [NUM_LINES-1:0] o_periph_in,
    output reg o_irq
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    wire [31:0] line_mask = `PIOC_LINE_MASK;
    wire [31:0] off_level = `PIOC_OFF_LEVEL;
    wire [31:0] owner_q;
    wire [31:0] dir_q;
    wire [31:0] data_q;
    wire [31:0] filt_q;
    wire [31:0] mask_q;
    reg [31:0] stat_q;
    wire [31:0] od_q;
    reg [NUM_LINES-1:0] sync1_q;
    reg [NUM_LINES-1:0] sync2_q;
    reg [NUM_LINES-1:0] sync3_q;
    reg [NUM_LINES-1:0] level_q;
    reg [NUM_LINES-1:0] prev_q;
    // bus handshake states: waiting for a request, or completing one
    localparam BUS_IDLE = 1'b0;
    localparam BUS_ACK = 1'b1;
    reg ack_q;
    reg ack_d;

    wire [31:0] wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
        {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
    wire [31:0] wbits = i_avs_writedata & wmask & line_mask;
    // one-cycle wait state: the access completes on the edge where ack_q is high
    wire acc_rd = i_avs_read & ack_q;
    wire acc_wr = i_avs_write & ack_q;

    function wr_hit;
        input [7:0] ofs;
        wr_hit = acc_wr && (i_avs_address == ofs);
    endfunction

    // ------------------------------------------------------------
    // change-detect arming after reset
    // ------------------------------------------------------------
    // the sample chain leaves reset at zero while a pulled-up pin idles high;
    // refilling the chain must not look like a pin change, so detection waits
    // until the chain holds real samples (a move in that window is not seen)
    reg [2:0] arm_q;
    wire armed = (arm_q == `PIOC_ARM_CYCLES);

    always @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            arm_q <= 3'h0;
        end
        else if (!armed)
        begin
            arm_q <= arm_q + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // input path: synchroniser, filter, change detect
    // ------------------------------------------------------------
    wire [NUM_LINES-1:0] filt_l = filt_q[NUM_LINES-1:0];
    // filtered value only moves when two successive samples agree
    wire [NUM_LINES-1:0] stable = ~(sync2_q ^ sync3_q);
    wire [NUM_LINES-1:0] level_d = (filt_l & stable & sync2_q) |
        (filt_l & ~stable & level_q) | (~filt_l & sync2_q);
    wire [NUM_LINES-1:0] change = (level_q ^ prev_q) & {NUM_LINES{armed}};

    always @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            sync1_q <= {NUM_LINES{1'b0}};
            sync2_q <= {NUM_LINES{1'b0}};
            sync3_q <= {NUM_LINES{1'b0}};
            level_q <= {NUM_LINES{1'b0}};
            prev_q <= {NUM_LINES{1'b0}};
        end
        else
        begin
            sync1_q <= i_pin;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            level_q <= level_d;
            prev_q <= level_q;
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // write strobes fire on the completing edge of a write to their offset
    wire set_owner = wr_hit(`PIOC_OWNER_CTRL_OFS);
    wire clr_owner = wr_hit(`PIOC_OWNER_PERIPH_OFS);
    wire set_dir = wr_hit(`PIOC_OUT_EN_OFS);
    wire clr_dir = wr_hit(`PIOC_OUT_DIS_OFS);
    wire set_data = wr_hit(`PIOC_SET_DATA_OFS);
    wire clr_data = wr_hit(`PIOC_CLR_DATA_OFS);
    wire set_filt = wr_hit(`PIOC_FILT_EN_OFS);
    wire clr_filt = wr_hit(`PIOC_FILT_DIS_OFS);
    wire set_mask = wr_hit(`PIOC_IRQ_EN_OFS);
    wire clr_mask = wr_hit(`PIOC_IRQ_DIS_OFS);
    wire set_od = wr_hit(`PIOC_OD_EN_OFS);
    wire clr_od = wr_hit(`PIOC_OD_DIS_OFS);
    // lines without a peripheral signal stay with the controller
    wire [31:0] periph_lines = `PIOC_PERIPH_LINES;

    // pin ownership: ones select the controller
    pioc_setclr #(
        .WIDTH(32),
        .RESET_VAL(`PIOC_LINE_MASK)
    ) u_owner (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_set(set_owner),
        .i_clr(clr_owner),
        .i_bits(wbits & periph_lines),
        .o_q(owner_q)
    );

    // direction: ones make the line an output
    pioc_setclr #(
        .WIDTH(32),
        .RESET_VAL(`PIOC_ZERO)
    ) u_dir (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_set(set_dir),
        .i_clr(clr_dir),
        .i_bits(wbits),
        .o_q(dir_q)
    );

    // output data latch
    pioc_setclr #(
        .WIDTH(32),
        .RESET_VAL(`PIOC_ZERO)
    ) u_data (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_set(set_data),
        .i_clr(clr_data),
        .i_bits(wbits),
        .o_q(data_q)
    );

    // glitch filter switches
    pioc_setclr #(
        .WIDTH(32),
        .RESET_VAL(`PIOC_ZERO)
    ) u_filt (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_set(set_filt),
        .i_clr(clr_filt),
        .i_bits(wbits),
        .o_q(filt_q)
    );

    // change interrupt mask
    pioc_setclr #(
        .WIDTH(32),
        .RESET_VAL(`PIOC_ZERO)
    ) u_mask (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_set(set_mask),
        .i_clr(clr_mask),
        .i_bits(wbits),
        .o_q(mask_q)
    );

    // open-drain switches
    pioc_setclr #(
        .WIDTH(32),
        .RESET_VAL(`PIOC_ZERO)
    ) u_od (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_set(set_od),
        .i_clr(clr_od),
        .i_bits(wbits),
        .o_q(od_q)
    );

    // ------------------------------------------------------------
    // change interrupt status
    // ------------------------------------------------------------
    wire [31:0] chg32 = {{(32-NUM_LINES){1'b0}}, change};
    // only the bits that the completing read returned are cleared; a bit set
    // on the edge that loaded the read data is kept for the next read
    wire [31:0] stat_clr = (acc_rd && i_avs_address == `PIOC_IRQ_STATUS_OFS) ?
        o_avs_readdata : `PIOC_ZERO;

    always @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            stat_q <= `PIOC_ZERO;
        end
        else
        begin
            // a change in the clearing cycle survives the read
            stat_q <= ((stat_q & ~stat_clr) | chg32) & line_mask;
        end
    end

    // ------------------------------------------------------------
    // pin drive and peripheral input
    // ------------------------------------------------------------
    wire [NUM_LINES-1:0] own = owner_q[NUM_LINES-1:0];
    wire [NUM_LINES-1:0] od = od_q[NUM_LINES-1:0];
    wire [NUM_LINES-1:0] val = (own & data_q[NUM_LINES-1:0]) | (~own & i_periph_out);
    wire [NUM_LINES-1:0] en = (own & dir_q[NUM_LINES-1:0]) | (~own & i_periph_oe);
    wire [NUM_LINES-1:0] oe_d = en & ~(od & val);
    wire [NUM_LINES-1:0] out_d = val & ~od;
    wire [NUM_LINES-1:0] pin_d = (own & off_level[NUM_LINES-1:0]) | (~own & level_q);

    always @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            o_pin <= {NUM_LINES{1'b0}};
            o_pin_oe <= {NUM_LINES{1'b0}};
            o_periph_in <= {NUM_LINES{1'b0}};
            o_irq <= 1'b0;
        end
        else
        begin
            o_pin <= out_d;
            o_pin_oe <= oe_d;
            o_periph_in <= pin_d;
            o_irq <= |(stat_q & mask_q);
        end
    end

    // ------------------------------------------------------------
    // avalon-mm read mux and wait state
    // ------------------------------------------------------------
    reg [31:0] rd_d;
    always @*
    begin
        case (i_avs_address)
            `PIOC_OWNER_STATUS_OFS: rd_d = owner_q | (line_mask & ~periph_lines);
            `PIOC_OUT_STATUS_OFS: rd_d = dir_q;
            `PIOC_FILT_STATUS_OFS: rd_d = filt_q;
            `PIOC_DATA_STATUS_OFS: rd_d = data_q;
            `PIOC_PIN_LEVEL_OFS: rd_d = {{(32-NUM_LINES){1'b0}}, level_q};
            `PIOC_IRQ_MASK_OFS: rd_d = mask_q;
            `PIOC_IRQ_STATUS_OFS: rd_d = stat_q;
            `PIOC_OD_STATUS_OFS: rd_d = od_q;
            default: rd_d = `PIOC_ZERO;
        endcase
    end

    // ------------------------------------------------------------
    // avalon-mm handshake
    // ------------------------------------------------------------
    always @*
    begin
        case (ack_q)
            BUS_IDLE: ack_d = (i_avs_read | i_avs_write) ? BUS_ACK : BUS_IDLE;
            BUS_ACK: ack_d = BUS_IDLE;
            default: ack_d = BUS_IDLE;
        endcase
    end

    always @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            ack_q <= BUS_IDLE;
            o_avs_readdata <= `PIOC_ZERO;
            o_avs_waitrequest <= 1'b1;
        end
        else
        begin
            ack_q <= ack_d;
            // waitrequest falls for exactly the cycle before the completing edge
            o_avs_waitrequest <= (ack_d != BUS_ACK);
            // loaded on the taking edge so the word stands at the completing one
            if (i_avs_read & (ack_q == BUS_IDLE))
            begin
                o_avs_readdata <= rd_d & line_mask;
            end
        end
    end

endmodule

// ------------------------------------------------------------
// set/clear register: writes of ones set or clear bits, zeros leave them
// ------------------------------------------------------------
module pioc_setclr #(
    parameter WIDTH = 32,
    parameter [31:0] RESET_VAL = 32'h00000000
) (
    input wire i_core_clk,
    input wire i_reset,
    input wire i_set,
    input wire i_clr,
    input wire [WIDTH-1:0] i_bits,
    output reg [WIDTH-1:0] o_q
);

    // set and clear sit at different offsets, so at most one fires per edge
    always @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            o_q <= RESET_VAL[WIDTH-1:0];
        end
        else if (i_set)
        begin
            o_q <= o_q | i_bits;
        end
        else if (i_clr)
        begin
            o_q <= o_q & ~i_bits;
        end
    end

endmodule
`default_nettype wire

// ---- pioc_map.vh ----
// register offsets, reset values and line layout of the parallel I/O controller
`ifndef PIOC_MAP_VH
`define PIOC_MAP_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define PIOC_OWNER_CTRL_OFS 8'h00
`define PIOC_OWNER_PERIPH_OFS 8'h04
`define PIOC_OWNER_STATUS_OFS 8'h08
`define PIOC_OUT_EN_OFS 8'h10
`define PIOC_OUT_DIS_OFS 8'h14
`define PIOC_OUT_STATUS_OFS 8'h18
`define PIOC_FILT_EN_OFS 8'h20
`define PIOC_FILT_DIS_OFS 8'h24
`define PIOC_FILT_STATUS_OFS 8'h28
`define PIOC_SET_DATA_OFS 8'h30
`define PIOC_CLR_DATA_OFS 8'h34
`define PIOC_DATA_STATUS_OFS 8'h38
`define PIOC_PIN_LEVEL_OFS 8'h3C
`define PIOC_IRQ_EN_OFS 8'h40
`define PIOC_IRQ_DIS_OFS 8'h44
`define PIOC_IRQ_MASK_OFS 8'h48
`define PIOC_IRQ_STATUS_OFS 8'h4C
`define PIOC_OD_EN_OFS 8'h50
`define PIOC_OD_DIS_OFS 8'h54
`define PIOC_OD_STATUS_OFS 8'h58

// ------------------------------------------------------------
// line layout and reset values
// ------------------------------------------------------------
`define PIOC_LINE_MASK 32'h3FFFFFFF
`define PIOC_OFF_LEVEL 32'h04000000
`define PIOC_ZERO 32'h00000000
`define PIOC_PERIPH_LINES 32'h3FFFFFFF
`define PIOC_ARM_CYCLES 3'h4

`endif

// ---- pioc_monitor.sv ----
// port-level assertions for the parallel I/O controller
`timescale 1ns/1ps
`default_nettype none
module pioc_monitor #(
    parameter NUM_LINES = 30
) (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic [NUM_LINES-1:0] i_pin,
    input wire logic [NUM_LINES-1:0] o_pin_oe,
    input wire logic [NUM_LINES-1:0] o_periph_in,
    input wire logic o_irq
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    logic [NUM_LINES-1:0] pin_q;
    logic [3:0] quiet_q;
    logic rd_done;
    assign rd_done = i_avs_read && !o_avs_waitrequest;
    // calm-input counter: a pin move in flight could legally re-raise irq
    always_ff @(posedge i_core_clk)
    begin
        pin_q <= i_pin;
        quiet_q <= (i_reset || pin_q != i_pin) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hF};
    end
    a_req_waits: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("request unanswered");
    a_ack_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("ack longer than one cycle");
    a_idle_holds: assert property (!i_avs_read && !i_avs_write |=> o_avs_waitrequest)
        else $error("ack without request");
    a_high_bits: assert property (rd_done |-> o_avs_readdata[31:30] == 2'h0)
        else $error("absent bits read nonzero");
    a_hole_zero: assert property (
        rd_done && i_avs_address == 8'h0C |-> o_avs_readdata == 32'h0)
        else $error("reserved offset read nonzero");
    a_reset_input: assert property ($fell(i_reset) |=> o_pin_oe == '0 && !o_irq)
        else $error("not quiet after reset");
    a_reset_default: assert property (
        $fell(i_reset) |=> o_periph_in == 30'h04000000) else $error("wrong default level");
    a_irq_clear: assert property (
        rd_done && i_avs_address == 8'h4C && quiet_q > 4'h8 |=> ##1 !o_irq)
        else $error("irq held after status read");
endmodule
bind pioc_top pioc_monitor #(.NUM_LINES(NUM_LINES)) u_monitor (.i_core_clk(i_core_clk),
    .i_reset(i_reset), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_pin(i_pin), .o_pin_oe(o_pin_oe),
    .o_periph_in(o_periph_in), .o_irq(o_irq));
`default_nettype wire

// ---- pioc_pins.sv ----
// board model: pad resolution with pull-ups and an external driver
`timescale 1ns/1ps
`default_nettype none
module pioc_pins (
    input wire logic [29:0] i_drive,
    input wire logic [29:0] i_drive_oe,
    input wire logic [29:0] i_ext_val,
    input wire logic [29:0] i_ext_oe,
    output logic [29:0] o_level
);
    // released lines float up through the board pull-up
    assign o_level = (i_drive_oe & i_drive) | (~i_drive_oe & ~(i_ext_oe & ~i_ext_val));
endmodule
`default_nettype wire

// ---- pioc_top_tb.sv ----
// self-checking bench for the parallel I/O controller
`timescale 1ns/1ps
`default_nettype none
module pioc_top_tb;
    logic clk = 1'h0, rst = 1'h1, rd = 1'h0, wr = 1'h0, wt, irq;
    logic [7:0] adr = 8'h0;
    logic [31:0] wd = 32'h0, rdat, v;
    logic [29:0] pin, dq, oe, pin_in, ev = '0, ee = '0, po = '0, poe = '0;
    logic [7:0] ra [8] = '{8'h08, 8'h18, 8'h28, 8'h38, 8'h48, 8'h58, 8'h0C, 8'h4C};
    int fail_count = 0, checks = 0, cyc = 0;
    always #20 clk = ~clk;
    pioc_top dut (.i_core_clk(clk), .i_reset(rst), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wt), .i_pin(pin), .o_pin(dq), .o_pin_oe(oe), .i_periph_out(po),
        .i_periph_oe(poe), .o_periph_in(pin_in), .o_irq(irq));
    pioc_pins pads (.i_drive(dq), .i_drive_oe(oe), .i_ext_val(ev), .i_ext_oe(ee), .o_level(pin));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            fail_count++;
            $display("ERROR %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {adr, wd, wr, rd} <= {a, d, w, ~w};
        @(posedge clk);
        while (wt !== 1'h0) @(posedge clk);
        v = rdat;
        {wr, rd} <= 2'h0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        chk(v, e);
    endtask
    task automatic settle;
        repeat (10) @(posedge clk);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // the sequence needs about 240 cycles; a hang ends the run
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            fail_count++;
            tally_and_finish;
        end
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        foreach (ra[i]) rc(ra[i], i ? 32'h0 : 32'h3FFFFFFF);
        bus(1'h1, 8'h10, 32'hFFFFFFFF);
        bus(1'h1, 8'h14, 32'hFFFF0000);
        rc(8'h18, 32'h0000FFFF);
        bus(1'h1, 8'h30, 32'h000000F0);
        bus(1'h1, 8'h34, 32'h00000030);
        rc(8'h38, 32'h000000C0);
        settle;
        chk(32'(oe), 32'h0000FFFF);
        rc(8'h3C, 32'h3FFF00C0);
        bus(1'h1, 8'h40, 32'hFFFFFFFF);
        bus(1'h1, 8'h44, 32'hFFFFFF00);
        rc(8'h48, 32'h000000FF);
        bus(1'h0, 8'h4C, 32'h0);
        bus(1'h1, 8'h30, 32'h00000001);
        settle;
        chk(32'(irq), 32'h1);
        rc(8'h4C, 32'h1);
        rc(8'h4C, 32'h0);
        ee <= 30'h00100000;
        settle;
        chk(32'(irq), 32'h0);
        rc(8'h4C, 32'h00100000);
        bus(1'h1, 8'h50, 32'hC0000002);
        rc(8'h58, 32'h00000002);
        settle;
        chk(32'({dq[1], oe[1]}), 32'h1);
        bus(1'h1, 8'h30, 32'h00000002);
        settle;
        chk(32'(oe[1]), 32'h0);
        rc(8'h3C, 32'h3FEF00C3);
        {po, poe} <= {30'h100, 30'h100};
        bus(1'h1, 8'h04, 32'h00000100);
        settle;
        chk(32'({dq[8], oe[8]}), 32'h3);
        rc(8'h08, 32'h3FFFFEFF);
        poe <= '0;
        settle;
        chk(32'({pin_in[8], oe[8]}), 32'h2);
        bus(1'h1, 8'h00, 32'h00000100);
        settle;
        chk(32'({pin_in, oe[8]}), 32'h08000001);
        for (int k = 0; k < 2; k++)
        begin
            bus(1'h1, k ? 8'h24 : 8'h20, 32'hFFFFFFFF);
            rc(8'h28, k ? 32'h0 : 32'h3FFFFFFF);
            bus(1'h0, 8'h4C, 32'h0);
            ev[20] <= 1'h1;
            @(posedge clk);
            ev[20] <= 1'h0;
            settle;
            rc(8'h4C, k ? 32'h00100000 : 32'h0);
        end
        tally_and_finish;
    end
endmodule
`default_nettype wire
